// ### design/qawd_multi_eval.sv
// Multi-answer watchdog sequence run evaluator (top)
`timescale 1ns/1ps
module qawd_multi_eval
    import qawd_pkg::*;
#(
    parameter int STEP_CYCLES = STEP_CYCLES_DFLT,
    parameter int FAIL_W      = FAIL_W_DFLT
) (
    input  wire logic                  CLK,
    input  wire logic                  NRST,
    input  wire logic                  QA_MODE_SELECT,
    input  wire logic                  CONFIG_UPDATE,
    input  wire logic                  ANSWER_STROBE,
    input  wire logic                  ANSWER_CORRECT,
    input  wire logic [WIN1_LEN_W-1:0] FIRST_WINDOW_LENGTH,
    input  wire logic [WIN2_LEN_W-1:0] SECOND_WINDOW_LENGTH,
    input  wire logic [CHAL_W-1:0]     CHALLENGE_NEXT,
    output logic                       ANSWER_ERROR_FLAG,
    output logic                       EARLY_ANSWER_FLAG,
    output logic                       SEQUENCE_ERROR_FLAG,
    output logic                       WINDOW_EXPIRED_FLAG,
    output logic [CHAL_W-1:0]          CHALLENGE_VALUE,
    output logic [1:0]                 ANSWER_COUNT,
    output logic [FAIL_W-1:0]          FAIL_COUNT,
    output logic                       RUN_END,
    output logic                       IN_SECOND_WINDOW
);
    localparam logic [FAIL_W-1:0] FAIL_MAX = '1;

    qawd_phase_t      phase;        // Current response window
    logic [CNT_W-1:0] w1_tot;       // Answers seen in window one
    logic [CNT_W-1:0] w1_cor;       // Correct answers in window one
    logic [CNT_W-1:0] w2_tot;       // Answers seen in window two
    logic [CNT_W-1:0] w2_cor;       // Correct answers in window two
    logic [CNT_W-1:0] next_w1_tot;
    logic [CNT_W-1:0] next_w1_cor;
    logic [CNT_W-1:0] next_w2_tot;
    logic [CNT_W-1:0] next_w2_cor;
    logic [CNT_W-1:0] next_tot;     // Run total including this cycle
    logic             active;       // Scoring enabled and a run open
    logic             ans;          // Answer byte accepted this cycle
    logic             expired;      // Current window timed out
    logic             end_now;      // Run closes on this edge
    logic             good_now;     // Run is a fully correct sequence
    logic             restart_tmr;  // Start timing a fresh window
    logic [WIN1_LEN_W-1:0] win_len; // Length of the window being timed

    // Mode select high parks the run; scoring only in multi-answer mode
    assign active = (phase != QAWD_IDLE) && !QA_MODE_SELECT;
    assign ans    = active && ANSWER_STROBE;

    // An answer landing on the expiry edge still counts to its window
    always_comb begin
        next_w1_tot = w1_tot;
        next_w1_cor = w1_cor;
        next_w2_tot = w2_tot;
        next_w2_cor = w2_cor;
        if (ans && phase == QAWD_WIN1) begin
            next_w1_tot = CNT_W'(w1_tot + 1'b1);
            next_w1_cor = CNT_W'(w1_cor + CNT_W'(ANSWER_CORRECT));
        end else if (ans && phase == QAWD_WIN2) begin
            next_w2_tot = CNT_W'(w2_tot + 1'b1);
            next_w2_cor = CNT_W'(w2_cor + CNT_W'(ANSWER_CORRECT));
        end
        next_tot = CNT_W'(next_w1_tot + next_w2_tot);
    end

    // Run ends on the fourth answer or at the close of window two
    assign end_now = active && !CONFIG_UPDATE
                   && ((next_tot == ANSWERS_PER_RUN)
                       || (phase == QAWD_WIN2 && expired));
    assign good_now = (next_w1_cor == GOOD_WIN1_CNT) && (next_w2_cor == GOOD_WIN2_CNT);

    // Config changes abort the run; no outcome is reported for it
    assign restart_tmr = (phase == QAWD_IDLE && !QA_MODE_SELECT)
                       || (active && (CONFIG_UPDATE || end_now
                                      || (phase == QAWD_WIN1 && expired)));

    // Window two field is narrower; zero-extend into the shared timer
    assign win_len = (phase == QAWD_WIN2) ? WIN1_LEN_W'(SECOND_WINDOW_LENGTH)
                                          : FIRST_WINDOW_LENGTH;

    // Single timer is reused for both windows since they never overlap
    qawd_win_timer #(
        .STEP_CYCLES (STEP_CYCLES),
        .LEN_W       (WIN1_LEN_W)
    ) u_timer (
        .clk     (CLK),
        .nrst    (NRST),
        .restart (restart_tmr),
        .length  (win_len),
        .expired (expired)
    );

    // Phase sequencing
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            phase <= QAWD_IDLE;
        end else if (QA_MODE_SELECT) begin
            phase <= QAWD_IDLE;
        end else begin
            case (phase)
                QAWD_IDLE: phase <= QAWD_WIN1;
                QAWD_WIN1: begin
                    if (CONFIG_UPDATE || end_now) begin
                        phase <= QAWD_WIN1;
                    end else if (expired) begin
                        phase <= QAWD_WIN2;
                    end
                end
                QAWD_WIN2: begin
                    if (CONFIG_UPDATE || end_now) begin
                        phase <= QAWD_WIN1;
                    end
                end
                default: phase <= QAWD_IDLE;
            endcase
        end
    end

    // Answer tallies, cleared whenever a run starts over
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            w1_tot <= '0;
            w1_cor <= '0;
            w2_tot <= '0;
            w2_cor <= '0;
        end else if (!active || CONFIG_UPDATE || end_now) begin
            w1_tot <= '0;
            w1_cor <= '0;
            w2_tot <= '0;
            w2_cor <= '0;
        end else begin
            w1_tot <= next_w1_tot;
            w1_cor <= next_w1_cor;
            w2_tot <= next_w2_tot;
            w2_cor <= next_w2_cor;
        end
    end

    // Status flags written as one group only on the run's end edge
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            ANSWER_ERROR_FLAG   <= 1'b0;
            EARLY_ANSWER_FLAG   <= 1'b0;
            SEQUENCE_ERROR_FLAG <= 1'b0;
            WINDOW_EXPIRED_FLAG <= 1'b0;
        end else if (end_now) begin
            // Any wrong byte marks an answer error; a perfect run clears all
            ANSWER_ERROR_FLAG   <= (next_w1_cor != next_w1_tot)
                                || (next_w2_cor != next_w2_tot);
            EARLY_ANSWER_FLAG   <= (next_w1_tot == ANSWERS_PER_RUN);
            // Fewer than three answers in window one breaks the sequence
            SEQUENCE_ERROR_FLAG <= (next_w1_tot < GOOD_WIN1_CNT);
            WINDOW_EXPIRED_FLAG <= (next_tot < ANSWERS_PER_RUN);
        end
    end

    // Failure counter saturates at both ends rather than wrapping
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            FAIL_COUNT <= '0;
        end else if (end_now && good_now) begin
            if (FAIL_COUNT != '0) begin
                FAIL_COUNT <= FAIL_W'(FAIL_COUNT - 1'b1);
            end
        end else if (end_now) begin
            if (FAIL_COUNT != FAIL_MAX) begin
                FAIL_COUNT <= FAIL_W'(FAIL_COUNT + 1'b1);
            end
        end
    end

    // Challenge latch; only a perfect run takes the next question, failed runs hold it
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            CHALLENGE_VALUE <= CHAL_RST;
        end else if (end_now && good_now) begin
            CHALLENGE_VALUE <= CHALLENGE_NEXT;
        end
    end

    // Status outputs: end pulse, window indicator, answer index counting down
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            RUN_END          <= 1'b0;
            IN_SECOND_WINDOW <= 1'b0;
            ANSWER_COUNT     <= ANS_COUNT_RST;
        end else begin
            RUN_END          <= end_now;
            IN_SECOND_WINDOW <= active && (phase == QAWD_WIN2) && !restart_tmr
                             || (active && phase == QAWD_WIN1 && expired
                                 && !end_now && !CONFIG_UPDATE);
            if (!active || CONFIG_UPDATE || end_now) begin
                ANSWER_COUNT <= ANS_COUNT_RST;
            end else begin
                ANSWER_COUNT <= 2'(ANS_IDX_LAST - next_tot[1:0]);
            end
        end
    end

    // Helper: cycles spent in the current window
    logic [31:0] win_cyc;
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            win_cyc <= '0;
        end else if (restart_tmr) begin
            win_cyc <= 32'h1;
        end else begin
            win_cyc <= win_cyc + 32'h1;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);

    a_mode_parks: assert property (QA_MODE_SELECT |=> phase == QAWD_IDLE && !end_now)
        else $error("run active while mode select high");
    a_flags_group: assert property ($changed({ANSWER_ERROR_FLAG, EARLY_ANSWER_FLAG,
            SEQUENCE_ERROR_FLAG, WINDOW_EXPIRED_FLAG}) |-> RUN_END)
        else $error("status flags moved outside run end");
    a_silent_run: assert property (end_now && next_tot == 3'h0 |=> SEQUENCE_ERROR_FLAG
            && WINDOW_EXPIRED_FLAG && !ANSWER_ERROR_FLAG && !EARLY_ANSWER_FLAG)
        else $error("empty run scored wrong");
    a_fourth_ends: assert property (ans && !CONFIG_UPDATE && w1_tot + w2_tot == 3'h3
            |=> RUN_END && ANSWER_COUNT == 2'h3)
        else $error("fourth answer did not end run");
    a_weak_first: assert property (end_now && next_w1_tot < 3'h3 |=> SEQUENCE_ERROR_FLAG
            && !EARLY_ANSWER_FLAG)
        else $error("weak first window not flagged");
    a_short_wrong: assert property (end_now && next_tot < 3'h4 && next_w2_tot == 3'h1
            && next_w2_cor == 3'h0 |=> ANSWER_ERROR_FLAG && WINDOW_EXPIRED_FLAG)
        else $error("single wrong answer not flagged");
    a_fail_inc: assert property (end_now && !good_now && FAIL_COUNT != FAIL_MAX
            |=> FAIL_COUNT == $past(FAIL_COUNT) + 1'b1)
        else $error("failure counter not incremented");
    a_keep_chal: assert property (end_now && !good_now |=> $stable(CHALLENGE_VALUE))
        else $error("challenge changed after failed run");
    a_good_run: assert property (end_now && good_now |=> !ANSWER_ERROR_FLAG
            && !EARLY_ANSWER_FLAG && !SEQUENCE_ERROR_FLAG && !WINDOW_EXPIRED_FLAG
            && CHALLENGE_VALUE == $past(CHALLENGE_NEXT))
        else $error("correct run not cleared");
    a_win_length: assert property (active && !CONFIG_UPDATE && phase == QAWD_WIN1
            && expired |-> win_cyc == (32'(FIRST_WINDOW_LENGTH) + 32'h1)
            * 32'(STEP_CYCLES))
        else $error("first window length wrong");

    c_good_run:  cover property (end_now && good_now);
    c_timeout:   cover property (end_now && phase == QAWD_WIN2 && expired);
    c_early:     cover property (end_now && next_w1_tot == 3'h4);
    c_cfg_abort: cover property (active && CONFIG_UPDATE);

endmodule

// ### design/qawd_pkg.sv
// Shared constants and types for the multi-answer watchdog run evaluator
package qawd_pkg;

    // Window step timing: one step is 0.55 ms of the 100 MHz system clock
    localparam int CLK_PERIOD_PS    = 10000;
    localparam int STEP_TIME_NS     = 550000;
    localparam int STEP_CYCLES_DFLT = (STEP_TIME_NS * 1000) / CLK_PERIOD_PS;

    // Field widths
    localparam int WIN1_LEN_W  = 8;
    localparam int WIN2_LEN_W  = 5;
    localparam int CHAL_W      = 4;
    localparam int CNT_W       = 3;
    localparam int FAIL_W_DFLT = 4;

    // Answers per run and the split of a fully correct run
    localparam logic [2:0] ANSWERS_PER_RUN = 3'h4;
    localparam logic [2:0] GOOD_WIN1_CNT   = 3'h3;
    localparam logic [2:0] GOOD_WIN2_CNT   = 3'h1;
    localparam logic [1:0] ANS_IDX_LAST    = 2'h3;

    // Values after reset
    localparam logic [3:0] CHAL_RST       = 4'h0;
    localparam logic [1:0] ANS_COUNT_RST  = 2'h3;

    // Run phases
    typedef enum logic [1:0] {
        QAWD_IDLE,
        QAWD_WIN1,
        QAWD_WIN2
    } qawd_phase_t;

endpackage

// ### design/qawd_win_timer.sv
// Response window timer counting whole 0.55 ms steps
`timescale 1ns/1ps
module qawd_win_timer #(
    parameter int STEP_CYCLES = 55000,
    parameter int LEN_W       = 8
) (
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             restart,
    input  wire logic [LEN_W-1:0] length,
    output logic                  expired
);
    localparam int PRE_W = $clog2(STEP_CYCLES + 1);
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(STEP_CYCLES - 1);

    logic [PRE_W-1:0] pre;    // Cycles inside the current step
    logic [LEN_W-1:0] steps;  // Whole steps elapsed

    // Prescaler and step counter; restart wins so each window starts clean
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pre   <= '0;
            steps <= '0;
        end else if (restart) begin
            pre   <= '0;
            steps <= '0;
        end else if (pre == PRE_LAST) begin
            pre   <= '0;
            steps <= LEN_W'(steps + 1'b1);
        end else begin
            pre   <= PRE_W'(pre + 1'b1);
        end
    end

    // Window lasts (length + 1) steps; owner restarts on this very cycle
    assign expired = (pre == PRE_LAST) && (steps == length);

endmodule

// ### verification/qawd_mcu_model.sv
// Microcontroller model that writes answer bytes as one-cycle strobes
`timescale 1ns/1ps
module qawd_mcu_model (
    input  wire logic clk,
    input  wire logic in_second_window,
    output logic      answer_strobe = 1'b0,
    output logic      answer_correct = 1'b0
);
    int stall_err = 0; // Waits for window two that ran out

    // Back to back answers, one a cycle; bit i of bad marks answer i wrong
    // Lets one edge pass first so a strobe just lowered is never raised in the same step
    // The qualifier is inverted when idle so it never looks held
    task automatic burst(input int n, input logic [3:0] bad);
        if (n > 0) begin
            @(posedge clk);
            #1;
            for (int i = 0; i < n; i++) begin
                answer_strobe  = 1'b1;
                answer_correct = ~bad[i];
                @(posedge clk);
                #1;
            end
            answer_strobe  = 1'b0;
            answer_correct = ~answer_correct;
        end
    endtask

    // One run: window one answers at once, the rest once window two is open
    task automatic run(input int n1, input logic [3:0] b1, input int n2, input logic [3:0] b2);
        int k;
        burst(n1, b1);
        k = 0;
        while (n2 > 0 && in_second_window !== 1'b1 && k < 200) begin
            @(posedge clk);
            #1;
            k++;
        end
        if (k == 200) begin
            stall_err++;
        end
        burst(n2, b2);
    endtask
endmodule

// ### verification/tb.sv
// Self-checking bench for the multi-answer watchdog run evaluator
`timescale 1ns/1ps
module tb;
    import qawd_pkg::*;
    localparam int SC = 4; // Short step keeps each window a few cycles long
    typedef struct {int n1; logic [3:0] b1; int n2; logic [3:0] b2; logic [3:0] fl;} qawd_row_t;
    logic       clk, nrst, mode_sel, cfg_update, strobe, correct, run_end, in_w2;
    logic       err, early, seq, expd;
    logic [7:0] len1;
    logic [4:0] len2;
    logic [3:0] chal_next, chal, fail, exp_chal;
    logic [1:0] ans_cnt;
    int         n_fail, check_count, exp_fail, n, p1, p2, p3;
    // Rows: window one count and wrong mask, window two likewise, flags {err,early,seq,expired}
    qawd_row_t  rows [11] = '{
        '{3, 4'h0, 1, 4'h0, 4'h0},
        '{0, 4'h0, 0, 4'h0, 4'h3},
        '{1, 4'h0, 3, 4'h5, 4'ha},
        '{2, 4'h0, 2, 4'h0, 4'h2},
        '{1, 4'h0, 1, 4'h0, 4'h3},
        '{2, 4'h0, 1, 4'h1, 4'hb},
        '{1, 4'h1, 2, 4'h0, 4'hb},
        '{4, 4'h0, 0, 4'h0, 4'h4},
        '{3, 4'h0, 1, 4'h0, 4'h0},
        '{3, 4'h2, 1, 4'h0, 4'h8},
        '{3, 4'h7, 0, 4'h0, 4'h9}
    };

    always #5 clk = ~clk;

    qawd_multi_eval #(.STEP_CYCLES(SC), .FAIL_W(4)) u_qawd_multi_eval (
        .CLK(clk), .NRST(nrst), .QA_MODE_SELECT(mode_sel), .CONFIG_UPDATE(cfg_update),
        .ANSWER_STROBE(strobe), .ANSWER_CORRECT(correct), .FIRST_WINDOW_LENGTH(len1),
        .SECOND_WINDOW_LENGTH(len2), .CHALLENGE_NEXT(chal_next), .ANSWER_ERROR_FLAG(err),
        .EARLY_ANSWER_FLAG(early), .SEQUENCE_ERROR_FLAG(seq), .WINDOW_EXPIRED_FLAG(expd),
        .CHALLENGE_VALUE(chal), .ANSWER_COUNT(ans_cnt), .FAIL_COUNT(fail),
        .RUN_END(run_end), .IN_SECOND_WINDOW(in_w2));

    qawd_mcu_model u_qawd_mcu_model (.clk(clk), .in_second_window(in_w2),
        .answer_strobe(strobe), .answer_correct(correct));

    // Compare seen against expected and count both
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    // Verdict and end of run
    task automatic results;
        if (n_fail == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Bounded wait for the end-of-run pulse; a stale pulse is skipped unless now is set
    task automatic wait_end(input bit now, output int cnt);
        cnt = 0;
        if (!now) begin
            @(posedge clk);
            #1;
            cnt = 1;
        end
        while (run_end !== 1'b1 && cnt < 300) begin
            @(posedge clk);
            #1;
            cnt++;
        end
        if (cnt >= 300) begin
            n_fail++;
            results();
        end
    endtask

    // Outcome of one run: flags, failure counter and challenge
    task automatic score(input logic [3:0] fl);
        if (fl == 4'h0) begin
            exp_fail = (exp_fail > 0) ? exp_fail - 1 : 0;
            exp_chal = chal_next;
        end else begin
            exp_fail = (exp_fail < 15) ? exp_fail + 1 : 15;
        end
        check("flags", {4'h0, err, early, seq, expd}, {4'h0, fl});
        check("fail count", {4'h0, fail}, 8'(exp_fail));
        check("challenge", {4'h0, chal}, {4'h0, exp_chal});
        check("answer count", {6'h0, ans_cnt}, 8'h3);
    endtask

    // Values that reset must give
    task automatic reset_vals;
        check("reset flags", {4'h0, err, early, seq, expd}, 8'h0);
        check("reset outputs", {run_end, in_w2, ans_cnt, chal}, {2'h0, ANS_COUNT_RST, CHAL_RST});
        check("reset fail", {4'h0, fail}, 8'h0);
    endtask

    initial begin
        clk = 1'b0;
        nrst = 1'b0;
        mode_sel = 1'b0;
        cfg_update = 1'b0;
        len1 = 8'h02;
        len2 = 5'h01;
        chal_next = 4'h5;
        n_fail = 0;
        check_count = 0;
        exp_fail = 0;
        exp_chal = CHAL_RST;
        repeat (4) @(posedge clk);
        #1;
        reset_vals();
        nrst = 1'b1;
        @(posedge clk);
        #1;
        // Ordinary runs, each starting in the first cycle of window one
        foreach (rows[i]) begin
            chal_next = chal_next + 4'h3;
            u_qawd_mcu_model.run(rows[i].n1, rows[i].b1, rows[i].n2, rows[i].b2);
            wait_end(rows[i].n1 + rows[i].n2 == 4, n);
            if (rows[i].n1 + rows[i].n2 == 4) check("end delay", 8'(n), 8'h0);
            score(rows[i].fl);
        end
        // Window lengths: one more step on either field lengthens the run by one step
        wait_end(1'b0, p1);
        score(4'h3);
        len1 = 8'h03;
        wait_end(1'b0, p2);
        score(4'h3);
        len2 = 5'h02;
        wait_end(1'b0, p3);
        score(4'h3);
        check("window one step", 8'(p2 - p1), 8'(SC));
        check("window two step", 8'(p3 - p2), 8'(SC));
        // Parked mode ignores answers and never ends a run
        mode_sel = 1'b1;
        u_qawd_mcu_model.burst(4, 4'h0);
        repeat (30) @(posedge clk);
        #1;
        check("parked count", {6'h0, ans_cnt}, 8'h3);
        check("parked flags", {4'h0, err, early, seq, expd}, 8'h3);
        mode_sel = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        u_qawd_mcu_model.run(3, 4'h0, 1, 4'h0);
        wait_end(1'b1, n);
        score(4'h0);
        // Update aborts a half-done run without scoring it
        u_qawd_mcu_model.burst(2, 4'h3);
        check("count mid run", {6'h0, ans_cnt}, 8'h1);
        cfg_update = 1'b1;
        @(posedge clk);
        #1;
        cfg_update = 1'b0;
        @(posedge clk);
        #1;
        check("aborted count", {6'h0, ans_cnt}, 8'h3);
        chal_next = 4'h9;
        u_qawd_mcu_model.run(3, 4'h0, 1, 4'h0);
        wait_end(1'b1, n);
        check("end delay", 8'(n), 8'h0);
        score(4'h0);
        check("window two wait", 8'(u_qawd_mcu_model.stall_err), 8'h0);
        // Reset in mid-run
        u_qawd_mcu_model.burst(2, 4'h0);
        nrst = 1'b0;
        #2;
        reset_vals();
        exp_fail = 0;
        exp_chal = CHAL_RST;
        // Release off the edge, then one idle edge before the first answer
        @(posedge clk);
        #1;
        nrst = 1'b1;
        @(posedge clk);
        #1;
        check("released count", {6'h0, ans_cnt}, 8'h3);
        chal_next = 4'h2;
        u_qawd_mcu_model.run(3, 4'h0, 1, 4'h0);
        wait_end(1'b1, n);
        check("end delay", 8'(n), 8'h0);
        score(4'h0);
        results();
    end
endmodule
